// ---- hw/tpo_pkg.sv ----
package tpo_pkg;

   // Register byte offsets (one aligned 32-bit word each)
   localparam logic [7:0] OFS_GROUP_A_BUF  = 8'h00;
   localparam logic [7:0] OFS_GROUP_A_CTRL = 8'h04;
   localparam logic [7:0] OFS_GROUP_B_BUF  = 8'h08;
   localparam logic [7:0] OFS_TRIG_SEL     = 8'h0C;
   localparam logic [7:0] OFS_HSW_CTRL     = 8'h10;
   localparam logic [7:0] OFS_PORT8_MODE   = 8'h14;
   localparam logic [7:0] OFS_PORT0_DIR    = 8'h18;
   localparam logic [7:0] OFS_PORT8_DIR    = 8'h1C;
   localparam logic [7:0] OFS_PORT0_DATA   = 8'h20;
   localparam logic [7:0] OFS_PORT8_DATA   = 8'h24;
   localparam logic [7:0] OFS_PORT0_PIN    = 8'h28;
   localparam logic [7:0] OFS_PORT8_PIN    = 8'h2C;

   // Group A control field positions
   localparam int CTRL_UPPER_EN   = 0;
   localparam int CTRL_LOWER_EN   = 1;
   localparam int CTRL_BYTE_MODE  = 2;
   localparam int CTRL_ALT_TRIG   = 3;
   // Group B buffer field positions
   localparam int BUFB_VS_LEVEL   = 0;
   localparam int BUFB_VS_HIZ     = 1;
   localparam int BUFB_VS_HSYNC   = 2;
   localparam int BUFB_VS_PATTERN = 3;
   // Port 8 mode field positions
   localparam int MODE_VS_EN      = 0;
   localparam int MODE_HSW_EN     = 2;
   localparam int MODE_ROT_EN     = 3;
   // Head switch control field positions
   localparam int HSW_HEAD_BIT    = 0;
   localparam int HSW_CHROMA_BIT  = 1;

   localparam logic [7:0] RESET_BYTE = 8'h00;

   // Pseudo vsync pattern default: length and bit shape
   localparam int          VS_PATTERN_LEN = 8;
   localparam logic [7:0]  VS_PATTERN     = 8'h3C;

   typedef enum logic [1:0] {
      TPO_SRC_T0_B,
      TPO_SRC_T0_C,
      TPO_SRC_T1_D,
      TPO_SRC_T5
   } tpo_src_t;

   typedef struct packed {
      logic t0_a;
      logic t0_b;
      logic t0_c;
      logic t1_d;
      logic t5;
      logic alt;
   } tpo_trig_t;

endpackage : tpo_pkg

// ---- hw/tpo_vsync_gen.sv ----
`timescale 1ns/1ps
module tpo_vsync_gen #(
   parameter int               PAT_LEN = tpo_pkg::VS_PATTERN_LEN,
   parameter logic [PAT_LEN-1:0] PATTERN = tpo_pkg::VS_PATTERN
) (
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic trigger,
   input  wire logic pattern_mode,
   input  wire logic level,
   input  wire logic hiz,
   input  wire logic hsync_mix,
   input  wire logic hsync,
   output logic      pin_out,
   output logic      pin_oe
);
   logic                       latched_level;
   logic                       latched_hiz;
   logic                       latched_mix;
   logic                       latched_pat;
   logic [$clog2(PAT_LEN)-1:0] pat_idx;

   // Level, hi-z and mix flags only change at the trigger instant
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         latched_level <= 1'b0;
         latched_hiz   <= 1'b1;
         latched_mix   <= 1'b0;
         latched_pat   <= 1'b0;
      end else if (trigger) begin
         latched_level <= level;
         latched_hiz   <= hiz;
         latched_mix   <= hsync_mix;
         latched_pat   <= pattern_mode;
      end
   end

   // Pattern restarts on every trigger and then repeats
   always_ff @(posedge clock) begin
      if (sys_rst || trigger) begin
         pat_idx <= '0;
      end else if (latched_pat) begin
         if (pat_idx == $clog2(PAT_LEN)'(PAT_LEN - 1)) begin
            pat_idx <= '0;
         end else begin
            pat_idx <= pat_idx + 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pin_out <= 1'b0;
         pin_oe  <= 1'b0;
      end else begin
         pin_oe <= ~latched_hiz;
         if (latched_pat) begin
            pin_out <= PATTERN[pat_idx] ^ (latched_mix & hsync);
         end else begin
            pin_out <= latched_level ^ (latched_mix & hsync);
         end
      end
   end
endmodule : tpo_vsync_gen

// ---- hw/tpo_axil_slave.sv ----
`timescale 1ns/1ps
module tpo_axil_slave (
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             wr_en,
   output logic [7:0]       wr_addr,
   output logic [7:0]       wr_data,
   input  wire logic        wr_ok,
   output logic [7:0]       rd_addr,
   input  wire logic [7:0]  rd_data,
   input  wire logic        rd_ok
);
   logic       aw_held;
   logic       w_held;
   logic [7:0] aw_q;
   logic [7:0] w_q;
   logic       w_lane;

   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign wr_addr       = aw_q;
   assign wr_data       = w_q;
   assign wr_en         = aw_held & w_held & w_lane;
   assign rd_addr       = s_axi_araddr;
   assign s_axi_arready = ~s_axi_rvalid;

   // Address and data may arrive in either order
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_q         <= 8'h00;
         w_q          <= 8'h00;
         w_lane       <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_q    <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_q    <= s_axi_wdata[7:0];
            w_lane <= s_axi_wstrb[0];
         end
         if (aw_held && w_held) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h00_0000, rd_ok ? rd_data : 8'h00};
         s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule : tpo_axil_slave

// ---- hw/tpo_timed_port.sv ----
`timescale 1ns/1ps
// Functional notes
// - Trigger copies buffer into output latch
// - Group A: two nibbles or one byte
// - Group B: bit 0, bits 2-3
// - Upper nibble loads on timer0 match B
// - Lower nibble/byte on match C or alternate
// - Bit 0 trigger chosen from four sources
// - Bits 2-3 follow head switch on match A
// - Head switch rewrite shows immediately
// - Vsync bit drives low, high, hi-z
// - Vsync bit can mix horizontal sync
// - Pattern mode repeats pattern per trigger
// - Unused port bits individually input or output
module tpo_timed_port #(
   parameter int                 PAT_LEN = tpo_pkg::VS_PATTERN_LEN,
   parameter logic [PAT_LEN-1:0] PATTERN = tpo_pkg::VS_PATTERN
) (
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire tpo_pkg::tpo_trig_t trig,
   input  wire logic        hsync,
   input  wire logic [7:0]  port0_in,
   output logic [7:0]       port0_out,
   output logic [7:0]       port0_oe,
   input  wire logic [7:0]  port8_in,
   output logic [7:0]       port8_out,
   output logic [7:0]       port8_oe
);
   logic [7:0] group_a_buf;
   logic [7:0] group_a_ctrl;
   logic [7:0] group_b_buf;
   logic [7:0] trig_sel;
   logic [7:0] head_switch_out_ctrl;
   logic [7:0] port8_mode_ctrl;
   logic [7:0] port0_dir;
   logic [7:0] port8_dir;
   logic [7:0] port0_data;
   logic [7:0] port8_data;
   logic [7:0] group_a_latch;
   logic [1:0] hsw_latch;
   logic       wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic       wr_ok;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   logic       rd_ok;
   logic       upper_trig;
   logic       lower_trig;
   logic       vs_trig;
   logic       vs_pin;
   logic       vs_oe;
   logic       hsw_write;
   logic [7:0] a_timed;
   logic [7:0] b_timed;
   logic [7:0] b_value;
   logic [7:0] b_oe;

   tpo_axil_slave u_bus (
      .clock         (clock),
      .sys_rst       (sys_rst),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wr_en         (wr_en),
      .wr_addr       (wr_addr),
      .wr_data       (wr_data),
      .wr_ok         (wr_ok),
      .rd_addr       (rd_addr),
      .rd_data       (rd_data),
      .rd_ok         (rd_ok)
   );

   // Register decode
   always_comb begin
      wr_ok = 1'b1;
      case (wr_addr)
         tpo_pkg::OFS_GROUP_A_BUF,  tpo_pkg::OFS_GROUP_A_CTRL,
         tpo_pkg::OFS_GROUP_B_BUF,  tpo_pkg::OFS_TRIG_SEL,
         tpo_pkg::OFS_HSW_CTRL,     tpo_pkg::OFS_PORT8_MODE,
         tpo_pkg::OFS_PORT0_DIR,    tpo_pkg::OFS_PORT8_DIR,
         tpo_pkg::OFS_PORT0_DATA,   tpo_pkg::OFS_PORT8_DATA: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         group_a_buf          <= tpo_pkg::RESET_BYTE;
         group_a_ctrl         <= tpo_pkg::RESET_BYTE;
         group_b_buf          <= tpo_pkg::RESET_BYTE;
         trig_sel             <= tpo_pkg::RESET_BYTE;
         head_switch_out_ctrl <= tpo_pkg::RESET_BYTE;
         port8_mode_ctrl      <= tpo_pkg::RESET_BYTE;
         port0_dir            <= tpo_pkg::RESET_BYTE;
         port8_dir            <= tpo_pkg::RESET_BYTE;
         port0_data           <= tpo_pkg::RESET_BYTE;
         port8_data           <= tpo_pkg::RESET_BYTE;
      end else if (wr_en) begin
         case (wr_addr)
            tpo_pkg::OFS_GROUP_A_BUF:  group_a_buf <= wr_data;
            tpo_pkg::OFS_GROUP_A_CTRL: group_a_ctrl <= wr_data;
            tpo_pkg::OFS_GROUP_B_BUF:  group_b_buf <= wr_data;
            tpo_pkg::OFS_TRIG_SEL:     trig_sel <= wr_data;
            tpo_pkg::OFS_HSW_CTRL:     head_switch_out_ctrl <= wr_data;
            tpo_pkg::OFS_PORT8_MODE:   port8_mode_ctrl <= wr_data;
            tpo_pkg::OFS_PORT0_DIR:    port0_dir <= wr_data;
            tpo_pkg::OFS_PORT8_DIR:    port8_dir <= wr_data;
            tpo_pkg::OFS_PORT0_DATA:   port0_data <= wr_data;
            tpo_pkg::OFS_PORT8_DATA:   port8_data <= wr_data;
            default: ;
         endcase
      end
   end

   always_comb begin
      rd_ok   = 1'b1;
      case (rd_addr)
         tpo_pkg::OFS_GROUP_A_BUF:  rd_data = group_a_buf;
         tpo_pkg::OFS_GROUP_A_CTRL: rd_data = group_a_ctrl;
         tpo_pkg::OFS_GROUP_B_BUF:  rd_data = group_b_buf;
         tpo_pkg::OFS_TRIG_SEL:     rd_data = trig_sel;
         tpo_pkg::OFS_HSW_CTRL:     rd_data = {6'h00, hsw_latch};
         tpo_pkg::OFS_PORT8_MODE:   rd_data = port8_mode_ctrl;
         tpo_pkg::OFS_PORT0_DIR:    rd_data = port0_dir;
         tpo_pkg::OFS_PORT8_DIR:    rd_data = port8_dir;
         tpo_pkg::OFS_PORT0_DATA:   rd_data = port0_data;
         tpo_pkg::OFS_PORT8_DATA:   rd_data = port8_data;
         tpo_pkg::OFS_PORT0_PIN:    rd_data = port0_in;
         tpo_pkg::OFS_PORT8_PIN:    rd_data = port8_in;
         default: begin
            rd_data = 8'h00;
            rd_ok   = 1'b0;
         end
      endcase
   end

   // Trigger routing
   assign upper_trig = trig.t0_b;
   assign lower_trig = group_a_ctrl[tpo_pkg::CTRL_ALT_TRIG] ?
                       trig.alt : trig.t0_c;
   always_comb begin
      case (tpo_pkg::tpo_src_t'(trig_sel[1:0]))
         tpo_pkg::TPO_SRC_T0_B: vs_trig = trig.t0_b;
         tpo_pkg::TPO_SRC_T0_C: vs_trig = trig.t0_c;
         tpo_pkg::TPO_SRC_T1_D: vs_trig = trig.t1_d;
         tpo_pkg::TPO_SRC_T5:   vs_trig = trig.t5;
         default:               vs_trig = 1'b0;
      endcase
   end

   // Group A latch; byte mode moves all eight bits on the lower trigger
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         group_a_latch <= tpo_pkg::RESET_BYTE;
      end else if (group_a_ctrl[tpo_pkg::CTRL_BYTE_MODE]) begin
         if (lower_trig) begin
            group_a_latch <= group_a_buf;
         end
      end else begin
         if (upper_trig) begin
            group_a_latch[7:4] <= group_a_buf[7:4];
         end
         if (lower_trig) begin
            group_a_latch[3:0] <= group_a_buf[3:0];
         end
      end
   end

   // Write wins over a same-cycle match so software sees its value at once
   assign hsw_write = wr_en && (wr_addr == tpo_pkg::OFS_HSW_CTRL);
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         hsw_latch <= 2'h0;
      end else if (hsw_write) begin
         hsw_latch <= wr_data[1:0];
      end else if (trig.t0_a) begin
         hsw_latch <= head_switch_out_ctrl[1:0];
      end
   end

   tpo_vsync_gen #(
      .PAT_LEN (PAT_LEN),
      .PATTERN (PATTERN)
   ) u_vsync (
      .clock        (clock),
      .sys_rst      (sys_rst),
      .trigger      (vs_trig),
      .pattern_mode (group_b_buf[tpo_pkg::BUFB_VS_PATTERN]),
      .level        (group_b_buf[tpo_pkg::BUFB_VS_LEVEL]),
      .hiz          (group_b_buf[tpo_pkg::BUFB_VS_HIZ]),
      .hsync_mix    (group_b_buf[tpo_pkg::BUFB_VS_HSYNC]),
      .hsync        (hsync),
      .pin_out      (vs_pin),
      .pin_oe       (vs_oe)
   );

   // Timed mode per nibble on group A, per bit on group B
   assign a_timed = {{4{group_a_ctrl[tpo_pkg::CTRL_UPPER_EN]}},
                     {4{group_a_ctrl[tpo_pkg::CTRL_LOWER_EN]}}};
   assign b_timed = {4'h0, port8_mode_ctrl[tpo_pkg::MODE_ROT_EN],
                     port8_mode_ctrl[tpo_pkg::MODE_HSW_EN], 1'b0,
                     port8_mode_ctrl[tpo_pkg::MODE_VS_EN]};
   assign b_value = {4'h0, hsw_latch[tpo_pkg::HSW_CHROMA_BIT],
                     hsw_latch[tpo_pkg::HSW_HEAD_BIT], 1'b0, vs_pin};
   assign b_oe    = {4'h0, 2'b11, 1'b0, vs_oe};

   // Pin drivers; outputs are registered
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_pin
         always_ff @(posedge clock) begin
            if (sys_rst) begin
               port0_out[i] <= 1'b0;
               port0_oe[i]  <= 1'b0;
               port8_out[i] <= 1'b0;
               port8_oe[i]  <= 1'b0;
            end else begin
               port0_out[i] <= a_timed[i] ? group_a_latch[i] : port0_data[i];
               port0_oe[i]  <= a_timed[i] | port0_dir[i];
               port8_out[i] <= b_timed[i] ? b_value[i] : port8_data[i];
               port8_oe[i]  <= b_timed[i] ? b_oe[i] : port8_dir[i];
            end
         end
      end
   endgenerate
endmodule : tpo_timed_port

// ---- testbench/tpo_port_monitor.sv ----
`timescale 1ns/1ps
module tpo_port_monitor (
   input wire logic               clock,
   input wire logic               sys_rst,
   input wire logic               s_axi_awvalid,
   input wire logic               s_axi_awready,
   input wire logic               s_axi_wvalid,
   input wire logic               s_axi_wready,
   input wire logic [1:0]         s_axi_bresp,
   input wire logic               s_axi_bvalid,
   input wire logic               s_axi_bready,
   input wire logic               s_axi_arvalid,
   input wire logic               s_axi_arready,
   input wire logic               s_axi_rvalid,
   input wire logic               s_axi_rready,
   input wire tpo_pkg::tpo_trig_t trig,
   input wire logic [7:0]         port0_out,
   input wire logic [7:0]         port0_oe,
   input wire logic [7:0]         port8_out,
   input wire logic [7:0]         port8_oe
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response not two cycles after handshake");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read data late");
   chk_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready
      |=> !s_axi_bvalid) else $error("write response repeated");
   chk_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready
      |=> !s_axi_rvalid) else $error("read data repeated");
   chk_reset_idle: assert property ($fell(sys_rst) |->
      port0_oe == 8'h00 && port8_oe == 8'h00)
      else $error("pins driven after reset");
   // Writes may move any pin, so they are excused as a cause
   chk_latch_on_trig: assert property ($changed(port0_out)
      && port0_oe == 8'hFF && $stable(port0_oe) |->
      ($past(trig, 2) & 6'h19) != 6'h00 || s_axi_bvalid
      || $past(s_axi_bvalid)) else $error("port 0 moved without trigger");
   chk_hsw_by_write: assert property ($changed(port8_out[3:2])
      && port8_oe[3:2] == 2'b11 && $stable(port8_oe[3:2]) |->
      s_axi_bvalid || $past(s_axi_bvalid))
      else $error("head switch moved without write");
   chk_oe_by_write: assert property ($changed(port0_oe)
      || $changed(port8_oe[7:2]) |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("drive enable moved without write");
   chk_vs_oe_cause: assert property ($changed(port8_oe[0]) |->
      ($past(trig, 3) & 6'h1E) != 6'h00 || s_axi_bvalid
      || $past(s_axi_bvalid)) else $error("vsync enable moved alone");

   cover property (trig.t0_b ##2 $changed(port0_out));
   cover property ($rose(port8_oe[0]));
   cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule : tpo_port_monitor

bind tpo_timed_port tpo_port_monitor chk (
   .clock(clock), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .trig(trig), .port0_out(port0_out), .port0_oe(port0_oe),
   .port8_out(port8_out), .port8_oe(port8_oe)
);

// ---- testbench/tpo_pin_model.sv ----
`timescale 1ns/1ps
module tpo_pin_model (
   input  wire logic [7:0] port0_out,
   input  wire logic [7:0] port0_oe,
   input  wire logic [7:0] port8_out,
   input  wire logic [7:0] port8_oe,
   input  wire logic [7:0] ext_en0,
   input  wire logic [7:0] ext_val0,
   input  wire logic [7:0] ext_en8,
   input  wire logic [7:0] ext_val8,
   output logic [7:0]      port0_in,
   output logic [7:0]      port8_in
);
   // Released pins float high through the input-mode pull-ups
   always_comb begin
      port0_in = (port0_oe & port0_out)
         | (~port0_oe & (~ext_en0 | ext_val0));
      port8_in = (port8_oe & port8_out)
         | (~port8_oe & (~ext_en8 | ext_val8));
   end
endmodule : tpo_pin_model

// ---- testbench/tb_timed_port_output_latch.sv ----
`timescale 1ns/1ps
module tb_timed_port_output_latch;
   localparam int BA = 0, CA = 1, BB = 2, TS = 3, HS = 4, M8 = 5;
   localparam int D0 = 6, D8 = 7, Q0 = 8, Q8 = 9;
   logic               clock = 1'b0, sys_rst = 1'b1, hsync = 1'b0;
   logic [7:0]         awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]        wdata = 32'h00000000, rdata;
   logic [3:0]         wstrb = 4'h0;
   // Answer readies stay high, so back-to-back calls never re-drive them
   logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
   logic               arvalid = 1'b0, rready = 1'b1;
   logic               awready, wready, bvalid, arready, rvalid;
   logic [1:0]         bresp, rresp;
   tpo_pkg::tpo_trig_t trig = '0;
   logic [7:0]         p0_in, p0_out, p0_oe, p8_in, p8_out, p8_oe;
   logic [7:0]         ext_en0 = 8'h00, ext_val0 = 8'h00;
   logic [7:0]         ext_en8 = 8'h00, ext_val8 = 8'h00;
   logic [7:0]         r [10];
   logic [7:0]         lat = 8'h00;
   logic               vs_lvl, vs_hiz, vs_mix, vs_pat, vs_known = 1'b0;
   int                 pidx = 0, error_cnt = 0, n_tests = 0, cyc = 0;
   logic [7:0]         ctl_tab [4] = '{8'h03, 8'h07, 8'h0F, 8'h01};
   logic [5:0]         src_tab [4] = '{6'h10, 6'h08, 6'h04, 6'h02};
   logic [5:0]         trig_a [3] = '{6'h10, 6'h08, 6'h01};
   logic [2:0]         vs_tab [4] = '{3'b000, 3'b001, 3'b010, 3'b101};

   always #50 clock = ~clock;

   tpo_timed_port uut (
      .clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .trig(trig), .hsync(hsync),
      .port0_in(p0_in), .port0_out(p0_out), .port0_oe(p0_oe),
      .port8_in(p8_in), .port8_out(p8_out), .port8_oe(p8_oe)
   );
   tpo_pin_model pins (
      .port0_out(p0_out), .port0_oe(p0_oe), .port8_out(p8_out),
      .port8_oe(p8_oe), .ext_en0(ext_en0), .ext_val0(ext_val0),
      .ext_en8(ext_en8), .ext_val8(ext_val8), .port0_in(p0_in),
      .port8_in(p8_in)
   );

   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict

   always @(posedge clock) begin
      cyc++;
      if (cyc == 6000) begin
         error_cnt++;
         give_verdict();
      end
   end

   task automatic fail(input string msg);
      error_cnt++;
      $display("wrong value at %0t: %s", $time, msg);
   endtask : fail

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      n_tests++;
      if (got !== exp) fail("bus response");
   endtask : chk_resp

   task automatic chk_data(input logic [31:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== {24'h000000, exp}) fail("read data");
   endtask : chk_data

   function automatic void exp_ports(output logic [7:0] o0, e0, o8, e8);
      e0 = r[D0];
      o0 = r[Q0];
      if (r[CA][0]) begin
         e0[7:4] = 4'hF;
         o0[7:4] = lat[7:4];
      end
      if (r[CA][1]) begin
         e0[3:0] = 4'hF;
         o0[3:0] = lat[3:0];
      end
      e8 = r[D8];
      o8 = r[Q8];
      if (r[M8][2]) {e8[2], o8[2]} = {1'b1, r[HS][0]};
      if (r[M8][3]) {e8[3], o8[3]} = {1'b1, r[HS][1]};
      if (r[M8][0]) begin
         e8[0] = !vs_hiz;
         o8[0] = (vs_pat ? tpo_pkg::VS_PATTERN[pidx] : vs_lvl)
            ^ (vs_mix & hsync);
      end
   endfunction : exp_ports

   function automatic logic [7:0] reg_exp(input int i);
      logic [7:0] o0, e0, o8, e8;
      exp_ports(o0, e0, o8, e8);
      if (i < 10) return r[i];
      return (e0 & o0) | (~e0 & (~ext_en0 | ext_val0));
   endfunction : reg_exp

   task automatic chk_ports();
      logic [7:0] o0, e0, o8, e8, m8;
      @(negedge clock);
      exp_ports(o0, e0, o8, e8);
      // Bit 1 is left unchecked; bit 0 is unknown until its first trigger
      m8 = (r[M8][0] && !vs_known) ? 8'hFC : 8'hFD;
      n_tests++;
      if (p0_oe !== e0 || (p0_out & e0) !== (o0 & e0)) fail("port 0 pins");
      n_tests++;
      if ((p8_oe & m8) !== (e8 & m8) || (p8_out & e8 & m8) !== (o8 & e8 & m8))
         fail("port 8 pins");
      @(posedge clock);
   endtask : chk_ports

   task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
                         input logic [3:0] s);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         aw_done |= awready;
         w_done |= wready;
      end while (!(aw_done && w_done));
      while (!bvalid) @(posedge clock);
      chk_resp(bresp, (a < 8'h30) ? 2'b00 : 2'b10);
      if (a < 8'h28 && s[0]) r[a[7:2]] = d;
      if (a == tpo_pkg::OFS_PORT8_MODE) vs_known = 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, input logic [7:0] ed);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clock); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge clock);
      chk_resp(rresp, (a < 8'h30) ? 2'b00 : 2'b10);
      chk_data(rdata, ed);
   endtask : axi_rd

   task automatic pulse(input logic [5:0] m);
      logic low;
      trig <= tpo_pkg::tpo_trig_t'(m);
      @(posedge clock);
      trig <= '0;
      low = r[CA][3] ? m[0] : m[3];
      if (r[CA][0] && ((m[4] && !r[CA][2]) || (r[CA][2] && low)))
         lat[7:4] = r[BA][7:4];
      if (r[CA][1] && low) lat[3:0] = r[BA][3:0];
      if (m[4 - int'(r[TS][1:0])]) begin
         {vs_pat, vs_mix, vs_hiz, vs_lvl} = r[BB][3:0];
         vs_known = 1'b1;
         pidx = 0;
      end
      @(posedge clock);
      // Vsync bit passes three registers, so it lags group A by a cycle
      @(posedge clock);
      chk_ports();
   endtask : pulse

   initial begin
      void'($urandom(14187));
      foreach (r[i]) r[i] = 8'h00;
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      ext_en0 <= 8'($urandom);
      ext_val0 <= 8'($urandom);
      @(posedge clock);
      for (int i = 0; i < 11; i++) axi_rd(8'(i * 4), reg_exp(i));
      axi_rd(8'h30, 8'h00);
      axi_wr(8'h34, 8'hA5, 4'hF);
      axi_wr(8'h18, 8'($urandom), 4'hF);
      axi_wr(8'h20, 8'($urandom), 4'hF);
      chk_ports();
      axi_wr(8'h20, 8'h5A, 4'h0);
      axi_rd(8'h20, r[Q0]);
      axi_rd(8'h28, reg_exp(10));
      foreach (ctl_tab[k]) begin
         axi_wr(8'h04, ctl_tab[k], 4'hF);
         for (int j = 0; j < 6; j++) begin
            axi_wr(8'h00, 8'($urandom), 4'hF);
            chk_ports();
            pulse(trig_a[$urandom % 3]);
         end
      end
      axi_wr(8'h1C, 8'($urandom), 4'hF);
      axi_wr(8'h24, 8'($urandom), 4'hF);
      axi_wr(8'h14, 8'h0D, 4'hF);
      for (int j = 0; j < 4; j++) begin
         axi_wr(8'h10, 8'(j), 4'hF);
         chk_ports();
         pulse(6'h20);
      end
      for (int s = 0; s < 4; s++) begin
         hsync <= 1'($urandom);
         axi_wr(8'h0C, 8'(s), 4'hF);
         axi_wr(8'h08, 8'(vs_tab[s]), 4'hF);
         pulse(src_tab[(s + 1) % 4]);
         pulse(src_tab[s]);
      end
      hsync <= 1'b0;
      axi_wr(8'h08, 8'h08, 4'hF);
      pulse(src_tab[3]);
      for (int i = 1; i < 16; i++) begin
         pidx = i % tpo_pkg::VS_PATTERN_LEN;
         chk_ports();
      end
      for (int i = 0; i < 10; i++) axi_rd(8'(i * 4), reg_exp(i));
      give_verdict();
   end
endmodule : tb_timed_port_output_latch
